/* include/sorl_pkg.sv */
// Constants and carrier types for the safety output release logic
package sorl_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BLINK_HZ = 5;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned DISC_LIMIT_MS = 500;
  localparam int unsigned DISC_LIMIT_CYC = (CLK_HZ / 1000) * DISC_LIMIT_MS;
  localparam int unsigned BTN_DEB_MS = 10;
  localparam int unsigned BTN_DEB_CYC = (CLK_HZ / 1000) * BTN_DEB_MS;
  localparam int unsigned SIG_DEB_CYC = 1;
  localparam int unsigned CNT_W = 32;

  // Reset values of the latched state
  localparam logic RST_OUT_EN = 1'b0;
  localparam logic RST_DISC_ERR = 1'b0;
  localparam logic RST_INT_ERR = 1'b0;
  localparam logic RST_BLINK = 1'b0;
  localparam logic RST_BTN_LEVEL = 1'b1;
  localparam logic RST_IN_LEVEL = 1'b0;

  // Status byte fields, bit 7 down to bit 0
  typedef struct packed {
    logic error_off;
    logic warning;
    logic limit_area;
    logic inputs_live;
    logic release_pending;
    logic reserved2;
    logic actuated;
    logic outputs_on;
  } sorl_status_t;

  // Command byte fields, bit 7 down to bit 0
  typedef struct packed {
    logic error_reset;
    logic disc_ack;
    logic [5:0] reserved;
  } sorl_cmd_t;

  localparam sorl_status_t RST_STATUS = '0;
  localparam sorl_cmd_t RST_CMD = '0;

  typedef enum logic [1:0] {
    ST_WAIT,
    ST_ON,
    ST_FAULT
  } sorl_state_t;

endpackage

/* hdl/sorl_debounce.sv */
// Two-stage synchroniser with a settle-time debouncer for one pin
`timescale 1ns/1ps
module sorl_debounce #(
  parameter int unsigned DEB_CYC = 1,
  parameter logic INIT = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_pin,
  output logic o_level
);

  logic sync1_ff;
  logic sync2_ff;
  logic level_ff;
  logic [sorl_pkg::CNT_W-1:0] cnt_ff;
  logic nxt_level;
  logic [sorl_pkg::CNT_W-1:0] nxt_cnt;

  always_comb begin
    nxt_level = level_ff;
    nxt_cnt = '0;
    if (sync2_ff != level_ff) begin
      // Level must hold for the full settle time before it is taken
      if (cnt_ff + 32'h0000_0001 >= sorl_pkg::CNT_W'(DEB_CYC)) begin
        nxt_level = sync2_ff;
      end else begin
        nxt_cnt = cnt_ff + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sync1_ff <= INIT;
      sync2_ff <= INIT;
      level_ff <= INIT;
      cnt_ff <= '0;
    end else begin
      sync1_ff <= i_pin;
      sync2_ff <= sync1_ff;
      level_ff <= nxt_level;
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_level = level_ff;

endmodule

/* hdl/sorl_release.sv */
// Release, latching and simultaneity monitoring for the safety outputs
// Contract
// RULE1 - Power-up: outputs off, yellow blinks 5 Hz
// RULE2 - Automatic variant: closed feedback enables, yellow steady
// RULE3 - Automatic variant: feedback button acts on closing
// RULE4 - Manual variant: feedback alone never enables outputs
// RULE5 - Manual variant: enable on reset button falling edge
// RULE6 - Simultaneity monitor active in last chain sensor
// RULE7 - Inputs off over 500 ms apart: off, error
// RULE8 - No re-enable until simultaneity error acknowledged
// RULE9 - Simultaneity error kept through supply loss
// RULE10 - Acknowledge on acknowledge button falling edge
// RULE11 - Acknowledge also by serial diagnostic command
// RULE12 - Status bit7 error; command bit7 error reset
// RULE13 - Fault clears: cause gone, bit7 falls or guard opens
// RULE14 - Command bit6 acknowledges discrepancy time error
// RULE15 - Status bit4 set while both inputs live
// RULE16 - Timer starts on first drop, stops on second
// RULE17 - Buttons synchronised and debounced before edge detect
`timescale 1ns/1ps
module sorl_release #(
  parameter int unsigned BLINK_HALF_CYC = sorl_pkg::BLINK_HALF_CYC,
  parameter int unsigned DISC_LIMIT_CYC = sorl_pkg::DISC_LIMIT_CYC,
  parameter int unsigned BTN_DEB_CYC = sorl_pkg::BTN_DEB_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_manual_release_variant,
  input wire logic i_simul_monitor_en,
  input wire logic i_actuated,
  input wire logic i_safety_input_a,
  input wire logic i_safety_input_b,
  input wire logic i_feedback_closed,
  input wire logic i_reset_button_n,
  input wire logic i_ack_button_n,
  input wire logic i_internal_fault,
  input wire logic i_nv_disc_error,
  input wire sorl_pkg::sorl_cmd_t i_cmd,
  output logic o_safety_output_a,
  output logic o_safety_output_b,
  output logic o_led_yellow,
  output logic o_led_red,
  output logic o_nv_disc_error,
  output sorl_pkg::sorl_status_t o_status
);

  logic in_a;
  logic in_b;
  logic fb_closed;
  logic rst_btn;
  logic ack_btn;

  // Pins pass the synchroniser; buttons also need the long settle time
  sorl_debounce #(.DEB_CYC(sorl_pkg::SIG_DEB_CYC), .INIT(sorl_pkg::RST_IN_LEVEL)) u_in_a (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_safety_input_a),
    .o_level(in_a)
  );
  sorl_debounce #(.DEB_CYC(sorl_pkg::SIG_DEB_CYC), .INIT(sorl_pkg::RST_IN_LEVEL)) u_in_b (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_safety_input_b),
    .o_level(in_b)
  );
  sorl_debounce #(.DEB_CYC(sorl_pkg::SIG_DEB_CYC), .INIT(sorl_pkg::RST_IN_LEVEL)) u_fb (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_feedback_closed),
    .o_level(fb_closed)
  );
  sorl_debounce #(.DEB_CYC(BTN_DEB_CYC), .INIT(sorl_pkg::RST_BTN_LEVEL)) u_rst_btn ( // see RULE17
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_reset_button_n),
    .o_level(rst_btn)
  );
  sorl_debounce #(.DEB_CYC(BTN_DEB_CYC), .INIT(sorl_pkg::RST_BTN_LEVEL)) u_ack_btn ( // see RULE17
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_ack_button_n),
    .o_level(ack_btn)
  );

  // Actuation input passes a two-flop synchroniser; fault and command inputs share the clock domain
  logic act_s1_ff;
  logic act_ff;

  // Edge history
  logic rst_btn_d_ff;
  logic ack_btn_d_ff;
  logic cmd_rst_d_ff;
  logic cmd_ack_d_ff;
  logic nxt_rst_btn_d;
  logic nxt_ack_btn_d;
  logic nxt_cmd_rst_d;
  logic nxt_cmd_ack_d;

  logic rst_fall;
  logic ack_fall;
  logic cmd_rst_fall;
  logic cmd_ack_rise;

  always_comb begin
    nxt_rst_btn_d = rst_btn;
    nxt_ack_btn_d = ack_btn;
    nxt_cmd_rst_d = i_cmd.error_reset;
    nxt_cmd_ack_d = i_cmd.disc_ack;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rst_btn_d_ff <= sorl_pkg::RST_BTN_LEVEL;
      ack_btn_d_ff <= sorl_pkg::RST_BTN_LEVEL;
      cmd_rst_d_ff <= 1'b0;
      cmd_ack_d_ff <= 1'b0;
      act_s1_ff <= 1'b0;
      act_ff <= 1'b0;
    end else begin
      rst_btn_d_ff <= nxt_rst_btn_d;
      ack_btn_d_ff <= nxt_ack_btn_d;
      cmd_rst_d_ff <= nxt_cmd_rst_d;
      cmd_ack_d_ff <= nxt_cmd_ack_d;
      act_s1_ff <= i_actuated;
      act_ff <= act_s1_ff;
    end
  end

  assign rst_fall = rst_btn_d_ff & ~rst_btn; // see RULE5
  assign ack_fall = ack_btn_d_ff & ~ack_btn; // see RULE10
  assign cmd_rst_fall = cmd_rst_d_ff & ~i_cmd.error_reset; // see RULE13
  assign cmd_ack_rise = ~cmd_ack_d_ff & i_cmd.disc_ack; // see RULE11

  // Discrepancy monitor and latched errors
  logic [sorl_pkg::CNT_W-1:0] disc_cnt_ff;
  logic [sorl_pkg::CNT_W-1:0] nxt_disc_cnt;
  logic disc_err_ff;
  logic nxt_disc_err;
  logic int_err_ff;
  logic nxt_int_err;
  logic restored_ff;
  logic nxt_restored;
  logic disc_set;
  logic disc_ack;

  always_comb begin
    nxt_disc_cnt = '0;
    disc_set = 1'b0;
    // Exactly one input dropped: the other has this long to follow
    if (i_simul_monitor_en && (in_a ^ in_b)) begin // see RULE6, RULE16
      if (disc_cnt_ff + 32'h0000_0001 > sorl_pkg::CNT_W'(DISC_LIMIT_CYC)) begin
        disc_set = 1'b1; // see RULE7
        nxt_disc_cnt = disc_cnt_ff;
      end else begin
        nxt_disc_cnt = disc_cnt_ff + 32'h0000_0001;
      end
    end
    disc_ack = ack_fall | cmd_ack_rise; // see RULE10, RULE11, RULE14
    nxt_restored = 1'b1;
    nxt_disc_err = disc_err_ff;
    if (disc_ack) begin
      nxt_disc_err = 1'b0;
    end
    // Set wins over acknowledge in the same cycle
    if (disc_set) begin
      nxt_disc_err = 1'b1;
    end
    // First cycle after release picks up the stored error
    if (!restored_ff && i_nv_disc_error) begin // see RULE9
      nxt_disc_err = 1'b1;
    end
    nxt_int_err = int_err_ff;
    if (!i_internal_fault && (cmd_rst_fall || !act_ff)) begin // see RULE13
      nxt_int_err = 1'b0;
    end
    if (i_internal_fault) begin
      nxt_int_err = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      disc_cnt_ff <= '0;
      disc_err_ff <= sorl_pkg::RST_DISC_ERR;
      int_err_ff <= sorl_pkg::RST_INT_ERR;
      restored_ff <= 1'b0;
    end else begin
      disc_cnt_ff <= nxt_disc_cnt;
      disc_err_ff <= nxt_disc_err;
      int_err_ff <= nxt_int_err;
      restored_ff <= nxt_restored;
    end
  end

  // Release state machine
  sorl_pkg::sorl_state_t state_ff;
  sorl_pkg::sorl_state_t nxt_state;
  logic release_ok;
  logic any_err;

  assign any_err = disc_err_ff | int_err_ff | disc_set | i_internal_fault;
  // Feedback acts on its closed level, so no edge history is kept
  assign release_ok = act_ff & in_a & in_b & ~any_err; // see RULE8

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sorl_pkg::ST_WAIT: begin
        if (any_err) begin
          nxt_state = sorl_pkg::ST_FAULT;
        end else if (release_ok && fb_closed) begin
          // Manual needs the button edge; feedback level alone is not enough
          if (i_manual_release_variant) begin
            if (rst_fall) begin // see RULE4, RULE5
              nxt_state = sorl_pkg::ST_ON;
            end
          end else begin
            nxt_state = sorl_pkg::ST_ON; // see RULE2, RULE3
          end
        end
      end
      sorl_pkg::ST_ON: begin
        if (any_err) begin
          nxt_state = sorl_pkg::ST_FAULT; // see RULE7
        end else if (!release_ok || !fb_closed) begin
          nxt_state = sorl_pkg::ST_WAIT;
        end
      end
      sorl_pkg::ST_FAULT: begin
        if (!any_err) begin
          nxt_state = sorl_pkg::ST_WAIT; // see RULE8
        end
      end
      default: begin
        nxt_state = sorl_pkg::ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff <= sorl_pkg::ST_WAIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Blink divider, free running so the phase never stalls
  logic [sorl_pkg::CNT_W-1:0] blink_cnt_ff;
  logic [sorl_pkg::CNT_W-1:0] nxt_blink_cnt;
  logic blink_ff;
  logic nxt_blink;

  always_comb begin
    nxt_blink_cnt = blink_cnt_ff + 32'h0000_0001;
    nxt_blink = blink_ff;
    if (blink_cnt_ff + 32'h0000_0001 >= sorl_pkg::CNT_W'(BLINK_HALF_CYC)) begin
      nxt_blink_cnt = '0;
      nxt_blink = ~blink_ff; // see RULE1
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      blink_cnt_ff <= '0;
      blink_ff <= sorl_pkg::RST_BLINK;
    end else begin
      blink_cnt_ff <= nxt_blink_cnt;
      blink_ff <= nxt_blink;
    end
  end

  // Registered outputs
  logic out_en_ff;
  logic yellow_ff;
  logic red_ff;
  logic nv_err_ff;
  sorl_pkg::sorl_status_t status_ff;
  logic nxt_out_en;
  logic nxt_yellow;
  logic nxt_red;
  sorl_pkg::sorl_status_t nxt_status;

  always_comb begin
    nxt_out_en = (nxt_state == sorl_pkg::ST_ON); // see RULE1, RULE2
    nxt_red = (nxt_state == sorl_pkg::ST_FAULT);
    nxt_yellow = 1'b0;
    if (nxt_state == sorl_pkg::ST_ON) begin
      nxt_yellow = 1'b1; // see RULE2
    end else if (nxt_state == sorl_pkg::ST_WAIT) begin
      nxt_yellow = nxt_blink; // see RULE1
    end
    nxt_status = sorl_pkg::RST_STATUS;
    nxt_status.outputs_on = nxt_out_en;
    nxt_status.actuated = act_ff;
    nxt_status.release_pending = act_ff & ~nxt_out_en & (~fb_closed | i_manual_release_variant);
    nxt_status.inputs_live = in_a & in_b; // see RULE15
    nxt_status.warning = nxt_red;
    nxt_status.error_off = nxt_red; // see RULE12
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      out_en_ff <= sorl_pkg::RST_OUT_EN;
      yellow_ff <= 1'b0;
      red_ff <= 1'b0;
      nv_err_ff <= sorl_pkg::RST_DISC_ERR;
      status_ff <= sorl_pkg::RST_STATUS;
    end else begin
      out_en_ff <= nxt_out_en;
      yellow_ff <= nxt_yellow;
      red_ff <= nxt_red;
      nv_err_ff <= nxt_disc_err; // see RULE9
      status_ff <= nxt_status;
    end
  end

  assign o_safety_output_a = out_en_ff;
  assign o_safety_output_b = out_en_ff;
  assign o_led_yellow = yellow_ff;
  assign o_led_red = red_ff;
  assign o_nv_disc_error = nv_err_ff;
  assign o_status = status_ff;

endmodule

/* tb/sorl_release_checker.sv */
// Port-level assertions for the safety output release logic
`timescale 1ns/1ps
module sorl_release_checker #(
  parameter int unsigned DISC_LIMIT_CYC = 20,
  parameter int unsigned BTN_DEB_CYC = 3
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_manual_release_variant,
  input wire logic i_simul_monitor_en,
  input wire logic i_actuated,
  input wire logic i_safety_input_a,
  input wire logic i_safety_input_b,
  input wire logic i_feedback_closed,
  input wire logic i_reset_button_n,
  input wire logic i_internal_fault,
  input wire logic o_safety_output_a,
  input wire logic o_safety_output_b,
  input wire logic o_led_yellow,
  input wire logic o_led_red,
  input wire logic o_nv_disc_error,
  input wire sorl_pkg::sorl_status_t o_status
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  int mism;
  int since_rb;
  // Raw-pin counters; the design lags them by its synchronisers
  always_ff @(posedge i_clk) begin
    mism <= (i_resetn && i_simul_monitor_en && i_safety_input_a != i_safety_input_b) ? mism + 1 : 0;
    // Reset to the saturated value so the count is never unknown
    since_rb <= (!i_resetn) ? 99 : (!i_reset_button_n ? 0 : (since_rb < 99 ? since_rb + 1 : 99));
  end
  sequence s_fault;
    i_internal_fault [*4];
  endsequence
  sequence s_auto_ready;
    (!i_manual_release_variant && i_actuated && i_safety_input_a && i_safety_input_b && i_feedback_closed &&
     !i_internal_fault && !o_led_red && !o_nv_disc_error) [*8];
  endsequence
  a_outputs_pair: assert property (o_safety_output_a == o_safety_output_b) else $error("outputs differ");
  a_on_yellow_steady: assert property (o_safety_output_a |-> o_led_yellow) else $error("yellow off while on");
  a_auto_release: assert property (s_auto_ready |-> o_safety_output_a) else $error("no auto release");
  a_manual_edge: assert property (i_manual_release_variant && $rose(o_safety_output_a) |->
    since_rb <= BTN_DEB_CYC + 8) else $error("manual release without button");
  a_disc_sets: assert property (mism >= DISC_LIMIT_CYC + 10 |-> o_nv_disc_error) else $error("no disc error");
  a_err_blocks: assert property (o_nv_disc_error ##1 o_nv_disc_error |-> !o_safety_output_a)
    else $error("on with error");
  a_input_drop_off: assert property (!i_safety_input_a [*6] |-> !o_safety_output_a) else $error("on, input off");
  a_live_bit: assert property ((i_safety_input_a && i_safety_input_b) [*6] |-> o_status.inputs_live)
    else $error("live bit low");
  a_fault_shown: assert property (s_fault |-> o_led_red && o_status.error_off && !o_safety_output_b)
    else $error("fault not shown");
endmodule
bind sorl_release sorl_release_checker #(.DISC_LIMIT_CYC(DISC_LIMIT_CYC), .BTN_DEB_CYC(BTN_DEB_CYC)) u_chk (.*);

/* tb/sorl_button_model.sv */
// Operator side: presses the reset or acknowledge button
`timescale 1ns/1ps
module sorl_button_model #(
  parameter int PRESS_CYC = 10
) (
  input wire logic i_clk,
  input wire logic i_press_reset,
  input wire logic i_press_ack,
  output logic o_reset_button_n,
  output logic o_ack_button_n
);
  int rcnt = 0;
  int acnt = 0;
  // Held low past the debounce so the falling edge is a real press
  always @(posedge i_clk) begin
    rcnt <= i_press_reset ? PRESS_CYC : (rcnt > 0 ? rcnt - 1 : 0);
    acnt <= i_press_ack ? PRESS_CYC : (acnt > 0 ? acnt - 1 : 0);
  end
  assign o_reset_button_n = (rcnt == 0);
  assign o_ack_button_n = (acnt == 0);
endmodule

/* tb/sorl_release_tb.sv */
// Self-checking bench for the safety output release logic
`timescale 1ns/1ps
module sorl_release_tb;
  localparam int DL = 20;
  logic clk = 1'b0, rstn = 1'b0, man = 1'b0, mon = 1'b0, act = 1'b0, sa = 1'b0, sb = 1'b0, fb = 1'b0;
  logic flt = 1'b0, nv = 1'b0, prs_r = 1'b0, prs_a = 1'b0, rbn, abn, oa, ob, yel, red, nvo;
  sorl_pkg::sorl_cmd_t cmd = sorl_pkg::RST_CMD;
  sorl_pkg::sorl_status_t st;
  int errors = 0;
  int cmp_count = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  sorl_button_model btn (.i_clk(clk), .i_press_reset(prs_r), .i_press_ack(prs_a), .o_reset_button_n(rbn),
    .o_ack_button_n(abn));
  sorl_release #(.BLINK_HALF_CYC(8), .DISC_LIMIT_CYC(DL), .BTN_DEB_CYC(3)) dut (.i_clk(clk), .i_resetn(rstn),
    .i_manual_release_variant(man), .i_simul_monitor_en(mon), .i_actuated(act), .i_safety_input_a(sa),
    .i_safety_input_b(sb), .i_feedback_closed(fb), .i_reset_button_n(rbn), .i_ack_button_n(abn),
    .i_internal_fault(flt), .i_nv_disc_error(nv), .i_cmd(cmd), .o_safety_output_a(oa), .o_safety_output_b(ob),
    .o_led_yellow(yel), .o_led_red(red), .o_nv_disc_error(nvo), .o_status(st));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (exp !== got) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_out(input logic exp);
    for (int i = 0; i < 300 && oa !== exp; i++) begin
      cyc(1);
    end
    chk({7'h00, exp}, {7'h00, oa});
    if (oa !== exp) begin
      print_verdict();
    end
  endtask
  task automatic rst(input logic nv_v);
    rstn = 1'b0;
    nv = nv_v;
    cyc(6);
    rstn = 1'b1;
  endtask
  task automatic press(input logic ack_b);
    prs_r = !ack_b;
    prs_a = ack_b;
    cyc(1);
    prs_r = 1'b0;
    prs_a = 1'b0;
  endtask
  task automatic disc_err();
    sa = 1'b0;
    cyc(DL + 15);
    sb = 1'b0;
    cyc(3);
    sa = 1'b1;
    sb = 1'b1;
    cyc(40);
  endtask
  initial begin
    int n;
    logic p;
    n = 0;
    rst(1'b0);
    repeat (40) begin
      p = yel;
      cyc(1);
      n += (yel !== p);
    end
    chk({7'h00, oa}, 8'h00);
    chk({7'h00, n >= 4 && n <= 5}, 8'h01);
    $display("test power-up done");
    act = 1'b1;
    sa = 1'b1;
    sb = 1'b1;
    fb = 1'b1;
    wait_out(1'b1);
    chk({7'h00, yel}, 8'h01);
    chk({7'h00, ob}, 8'h01);
    chk(st, 8'h13);
    $display("test auto release done");
    man = 1'b1;
    rst(1'b0);
    cyc(40);
    chk({7'h00, oa}, 8'h00);
    chk(st, 8'h1a);
    press(1'b0);
    wait_out(1'b1);
    man = 1'b0;
    $display("test manual release done");
    mon = 1'b1;
    disc_err();
    chk({7'h00, oa}, 8'h00);
    chk({6'h00, st.error_off, nvo}, 8'h03);
    press(1'b1);
    wait_out(1'b1);
    sa = 1'b0;
    cyc(DL - 8);
    sb = 1'b0;
    cyc(3);
    sa = 1'b1;
    sb = 1'b1;
    wait_out(1'b1);
    chk({7'h00, nvo}, 8'h00);
    disc_err();
    chk({7'h00, oa}, 8'h00);
    cmd.disc_ack = 1'b1;
    wait_out(1'b1);
    cmd = sorl_pkg::RST_CMD;
    $display("test simultaneity done");
    flt = 1'b1;
    cyc(8);
    chk({4'h0, red, st.error_off, st.warning, yel}, 8'h0e);
    flt = 1'b0;
    cyc(20);
    chk({7'h00, oa}, 8'h00);
    cmd.error_reset = 1'b1;
    cyc(3);
    cmd = sorl_pkg::RST_CMD;
    wait_out(1'b1);
    $display("test internal fault done");
    mon = 1'b0;
    rst(1'b1);
    cyc(30);
    chk({6'h00, nvo, oa}, 8'h02);
    nv = 1'b0;
    press(1'b1);
    wait_out(1'b1);
    $display("test stored error done");
    print_verdict();
  end
endmodule
